/* lcd_display_ram_mux_scan.sv */
// Display memory, column pointer and multiplexed drive of a 4 x 44 segment LCD
//
// Behaviour
// - Memory holds four rows by 44 columns
// - One drives element on, zero drives off
// - Rows map to backplanes, columns to segments
// - Display register holds row data during slot
// - Fixed 1:4 multiplex, all backplanes scanned
// - Bias setting picks 1/2, 1/3, 1/4
// - Data byte stored at pointer column
// - Pointer advances two columns per byte
// - Byte fills two columns of four rows
// - Pointer stops at end; overflow discarded
// - Pointer load 10 plus column 0..43
// - Reset clears pointer; memory stays arbitrary
// - Reset keeps memory, defaults other state
`timescale 1ns/10ps
`include "lcd_defs.svh"

module lcd_display_ram_mux_scan #(
    parameter int SLOT_CYCLES = `CLK_HZ / (`FRAME_HZ * `SLOTS_PER_FRAME)
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output lcd_pkg::level_t [3:0] backplane_outputs,
    output lcd_pkg::level_t [43:0] segment_outputs
);
    import lcd_pkg::*;

    // ----------------------------------------
    // State and helpers
    // ----------------------------------------
    top_state_t r;
    top_state_t n;

    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    logic wr_go;
    logic at_byte;
    logic byte_wr;
    logic ptr_load;
    logic [7:0] cmd_byte;
    logic [`COL_W-1:0] ptr_sum;
    level_t top_lvl;
    logic tick;
    logic [1:0] scan_row;
    logic scan_phase;

    ram_if ram ();

    // ----------------------------------------
    // Sub-blocks
    // ----------------------------------------
    disp_ram u_ram (
        .aclk (aclk),
        .p (ram.store)
    );

    scan_gen #(
        .SLOT_CYCLES (SLOT_CYCLES)
    ) u_scan (
        .aclk (aclk),
        .aresetn (aresetn),
        .tick (tick),
        .row (scan_row),
        .phase (scan_phase)
    );

    assign ram.we = r.ram_we;
    assign ram.col = r.ram_col;
    assign ram.wbyte = r.ram_byte;
    assign ram.rd_row = scan_row;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    assign aw_hs = awvalid && r.awready;
    assign w_hs = wvalid && r.wready;
    assign ar_hs = arvalid && r.arready;
    assign wr_go = r.aw_have && r.w_have && !r.bvalid;
    assign cmd_byte = r.wdata[7:0];
    assign at_byte = wr_go && (r.awaddr == `ADDR_BYTE) && (r.wstrb[1:0] == 2'b11);
    assign byte_wr = at_byte && (r.wdata[9:8] == `RS_RAM);
    assign ptr_load = at_byte && (r.wdata[9:8] == `RS_CMD)
        && (cmd_byte[7:6] == `PTR_CMD_TAG);
    assign ptr_sum = r.ptr + `PTR_STEP;

    // Top drive level is a+1 for a bias of 1/(1+a)
    always_comb begin
        case (r.bias)
            BIAS_HALF: top_lvl = 3'd2;
            BIAS_THIRD: top_lvl = 3'd3;
            BIAS_QUARTER: top_lvl = 3'd4;
            default: top_lvl = 3'd3;
        endcase
    end

    // Second half of each row slot mirrors every level, so the cell sees no DC
    function automatic level_t drive(input level_t k, input logic ph, input level_t top);
        drive = ph ? level_t'(top - k) : k;
    endfunction : drive

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        n = r;
        n.ram_we = 1'b0;
        n.load_d1 = tick;

        // Write channel: address and data taken in either order
        if (r.bvalid && bready) begin
            n.bvalid = 1'b0;
        end
        if (aw_hs) begin
            n.aw_have = 1'b1;
            n.awaddr = awaddr;
        end
        if (w_hs) begin
            n.w_have = 1'b1;
            n.wdata = wdata;
            n.wstrb = wstrb;
        end
        if (wr_go) begin
            n.aw_have = 1'b0;
            n.w_have = 1'b0;
            n.bvalid = 1'b1;
            if (r.awaddr == `ADDR_BYTE || r.awaddr == `ADDR_CONFIG) begin
                n.bresp = `RESP_OKAY;
            end else begin
                n.bresp = `RESP_SLVERR;
            end
        end

        // Configuration byte lane 0; the reserved bias code leaves bias unchanged
        if (wr_go && r.awaddr == `ADDR_CONFIG && r.wstrb[0]) begin
            if (r.wdata[1:0] != `BIAS_RESERVED) begin
                n.bias = bias_t'(r.wdata[1:0]);
            end
            n.enable = r.wdata[2];
        end

        // Column pointer
        if (ptr_load) begin
            if (cmd_byte[5:0] <= `COL_LAST) begin
                n.ptr = cmd_byte[5:0];
                n.ptr_bad = 1'b0;
            end else begin
                n.ptr_bad = 1'b1;
            end
        end else if (byte_wr && !r.ptr_bad && r.ptr < `COL_END) begin
            n.ram_we = 1'b1;
            n.ram_col = r.ptr;
            n.ram_byte = cmd_byte;
            if (ptr_sum >= `COL_END) begin
                n.ptr = `COL_END;
            end else begin
                n.ptr = ptr_sum;
            end
        end

        // Read channel answers one cycle after the address is taken
        if (r.rvalid && rready) begin
            n.rvalid = 1'b0;
        end
        if (ar_hs) begin
            n.rvalid = 1'b1;
            n.rresp = `RESP_OKAY;
            n.rdata = '0;
            case (araddr)
                `ADDR_BYTE: n.rdata = '0;
                `ADDR_CONFIG: n.rdata[2:0] = {r.enable, r.bias};
                `ADDR_STATUS: n.rdata[10:0] = {r.disp_phase, r.disp_row,
                    r.ptr == `COL_END, r.ptr_bad, r.ptr};
                default: n.rresp = `RESP_SLVERR;
            endcase
        end

        // Display register: a row is caught once per slot and then held
        if (r.load_d1) begin
            n.disp = ram.rd_data;
            n.disp_row = scan_row;
            n.disp_phase = scan_phase;
        end

        // Drive levels: selected backplane at the top, others at level 1;
        // segment at 0 when on, 2 when off; all at ground while disabled
        for (int i = 0; i < `ROWS; i++) begin
            if (!r.enable) begin
                n.bp[i] = '0;
            end else if (r.disp_row == 2'(i)) begin
                n.bp[i] = drive(top_lvl, r.disp_phase, top_lvl);
            end else begin
                n.bp[i] = drive(3'd1, r.disp_phase, top_lvl);
            end
        end
        for (int c = 0; c < `COLS; c++) begin
            if (!r.enable) begin
                n.seg[c] = '0;
            end else if (r.disp[c]) begin
                n.seg[c] = drive(3'd0, r.disp_phase, top_lvl);
            end else begin
                n.seg[c] = drive(3'd2, r.disp_phase, top_lvl);
            end
        end

        // One write and one read outstanding at most
        n.awready = !n.aw_have && !n.bvalid;
        n.wready = !n.w_have && !n.bvalid;
        n.arready = !n.rvalid;
    end

    // ----------------------------------------
    // Registers; memory lives in its own module and is not reset
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign awready = r.awready;
    assign wready = r.wready;
    assign bvalid = r.bvalid;
    assign bresp = r.bresp;
    assign arready = r.arready;
    assign rvalid = r.rvalid;
    assign rdata = r.rdata;
    assign rresp = r.rresp;
    assign backplane_outputs = r.bp;
    assign segment_outputs = r.seg;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    ptr_advance_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (byte_wr && !ptr_load && !r.ptr_bad && r.ptr < 6'd42)
        |=> (r.ptr == $past(r.ptr) + 6'd2))
        else $error("pointer did not advance by two");

    ptr_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (byte_wr && !r.ptr_bad && r.ptr >= 6'd42) |=> (r.ptr == 6'd44) [*2])
        else $error("pointer did not stop at the end");

    ptr_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ptr_load && cmd_byte[5:0] <= 6'd43)
        |=> (r.ptr == $past(cmd_byte[5:0]) && !r.ptr_bad))
        else $error("valid pointer load not taken");

    ptr_reject_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ptr_load && cmd_byte[5:0] > 6'd43) |=> (r.ptr_bad && $stable(r.ptr)))
        else $error("out of range pointer not ignored");

    ram_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (byte_wr && !r.ptr_bad && r.ptr < 6'd44)
        |=> (r.ram_we && r.ram_col == $past(r.ptr) && r.ram_byte == $past(cmd_byte))
        ##1 !r.ram_we)
        else $error("data byte not written at pointer");

    no_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (byte_wr && (r.ptr_bad || r.ptr == 6'd44)) |=> !r.ram_we)
        else $error("byte written past end or with bad pointer");

    reset_ptr_a: assert property (@(posedge aclk)
        $rose(aresetn) |-> (r.ptr == 6'd0 && !r.ptr_bad && !r.enable))
        else $error("pointer not cleared by reset");

    disp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !r.load_d1 |=> $stable(r.disp))
        else $error("display register changed inside a slot");

    bp_select_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (r.enable && !r.disp_phase) |=> (r.bp[$past(r.disp_row)] == $past(top_lvl)))
        else $error("active backplane not at top level");

    seg_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (r.enable && !r.disp_phase) |=> (r.seg[0] == ($past(r.disp[0]) ? 3'd0 : 3'd2)))
        else $error("segment level does not follow stored bit");

    seg_last_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (r.enable && !r.disp_phase) |=> (r.seg[43] == ($past(r.disp[43]) ? 3'd0 : 3'd2)))
        else $error("last segment level does not follow stored bit");

    ram_select_a: assert property (@(posedge aclk) disable iff (!aresetn)
        r.ram_we |-> $past(byte_wr))
        else $error("memory written without a data byte");

    bias_half_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (r.enable && !r.disp_phase && r.bias == BIAS_HALF)
        |=> (r.bp[$past(r.disp_row)] == 3'd2))
        else $error("half bias top level wrong");

    bias_third_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (r.enable && !r.disp_phase && r.bias == BIAS_THIRD)
        |=> (r.bp[$past(r.disp_row)] == 3'd3))
        else $error("third bias top level wrong");

    bias_quarter_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (r.enable && !r.disp_phase && r.bias == BIAS_QUARTER)
        |=> (r.bp[$past(r.disp_row)] == 3'd4))
        else $error("quarter bias top level wrong");

    bp_other_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (r.enable && !r.disp_phase && r.disp_row != 2'd0) |=> (r.bp[0] == 3'd1))
        else $error("idle backplane not at level one");

    bp_mirror_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (r.enable && r.disp_phase) |=> (r.bp[$past(r.disp_row)] == 3'd0))
        else $error("active backplane not at ground in second half");

    drive_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !r.enable |=> (r.bp == '0 && r.seg == '0))
        else $error("outputs not at ground while display is off");

endmodule : lcd_display_ram_mux_scan

/* lcd_defs.svh */
// Offsets, field positions and timing figures of the LCD scan block
`ifndef LCD_DEFS_SVH
`define LCD_DEFS_SVH

// ----------------------------------------
// Display memory geometry
// ----------------------------------------
`define ROWS 4
`define COLS 44
`define COL_W 6
`define COL_LAST 6'd43
`define COL_END 6'd44
`define PTR_STEP 6'd2
`define LVL_W 3

// ----------------------------------------
// Byte and configuration register fields
// ----------------------------------------
`define RS_RAM 2'b01
`define RS_CMD 2'b00
`define PTR_CMD_TAG 2'b10
`define BIAS_RESERVED 2'b11

// ----------------------------------------
// Register byte addresses and responses
// ----------------------------------------
`define ADDR_BYTE 8'h00
`define ADDR_CONFIG 8'h04
`define ADDR_STATUS 8'h08
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_HZ 125000000
`define FRAME_HZ 200
`define SLOTS_PER_FRAME 8
`define SLOT_CNT_W 17

`endif

/* lcd_pkg.sv */
// Types shared by the LCD scan block modules
`include "lcd_defs.svh"

package lcd_pkg;

    typedef enum logic [1:0] {
        BIAS_THIRD = 2'b00,
        BIAS_HALF = 2'b01,
        BIAS_QUARTER = 2'b10
    } bias_t;

    typedef logic [`LVL_W-1:0] level_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic aw_have;
        logic w_have;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [`COL_W-1:0] ptr;
        logic ptr_bad;
        bias_t bias;
        logic enable;
        logic ram_we;
        logic [`COL_W-1:0] ram_col;
        logic [7:0] ram_byte;
        logic load_d1;
        logic [`COLS-1:0] disp;
        logic [1:0] disp_row;
        logic disp_phase;
        level_t [`ROWS-1:0] bp;
        level_t [`COLS-1:0] seg;
    } top_state_t;

    typedef struct packed {
        logic [`SLOT_CNT_W-1:0] cnt;
        logic [1:0] row;
        logic phase;
        logic tick;
    } scan_state_t;

    typedef struct packed {
        logic [`ROWS-1:0][`COLS-1:0] cells;
        logic [`COLS-1:0] rd;
    } mem_state_t;

endpackage : lcd_pkg

/* ram_if.sv */
// Write and read port of the display memory
`timescale 1ns/10ps
`include "lcd_defs.svh"

interface ram_if;
    logic we;
    logic [`COL_W-1:0] col;
    logic [7:0] wbyte;
    logic [1:0] rd_row;
    logic [`COLS-1:0] rd_data;

    modport owner (output we, output col, output wbyte, output rd_row, input rd_data);
    modport store (input we, input col, input wbyte, input rd_row, output rd_data);
endinterface : ram_if

/* disp_ram.sv */
// Four by forty-four bit display memory, byte written as two columns
`timescale 1ns/10ps
`include "lcd_defs.svh"

module disp_ram (
    input wire logic aclk,
    ram_if.store p
);
    import lcd_pkg::*;

    mem_state_t m;
    mem_state_t n;
    logic [`COLS-1:0] hit_hi;
    logic [`COLS-1:0] hit_lo;

    // ----------------------------------------
    // Column selects; a low nibble past column 43 has no column and is lost
    // ----------------------------------------
    genvar c;
    generate
        for (c = 0; c < `COLS; c++) begin : g_col
            assign hit_hi[c] = p.we && (p.col == `COL_W'(c));
            assign hit_lo[c] = p.we && (p.col + `COL_W'(1) == `COL_W'(c));
        end
    endgenerate

    always_comb begin
        n = m;
        for (int r = 0; r < `ROWS; r++) begin
            for (int k = 0; k < `COLS; k++) begin
                if (hit_hi[k]) begin
                    n.cells[r][k] = p.wbyte[7-r];
                end else if (hit_lo[k]) begin
                    n.cells[r][k] = p.wbyte[3-r];
                end
            end
        end
        n.rd = m.cells[p.rd_row];
    end

    // No reset: contents survive a reset and start out arbitrary
    always_ff @(posedge aclk) begin
        m <= n;
    end

    assign p.rd_data = m.rd;

    hi_nibble_a: assert property (@(posedge aclk)
        p.we |=> (m.cells[0][$past(p.col)] == $past(p.wbyte[7])))
        else $error("high nibble bit 7 not stored in row 0");

    lo_nibble_a: assert property (@(posedge aclk)
        (p.we && p.col < 6'd43) |=> (m.cells[3][$past(p.col) + 6'd1] == $past(p.wbyte[0])))
        else $error("low nibble bit 0 not stored in next column");

endmodule : disp_ram

/* scan_gen.sv */
// Slot divider and backplane row sequencer
`timescale 1ns/10ps
`include "lcd_defs.svh"

module scan_gen #(
    parameter int SLOT_CYCLES = 78125
) (
    input wire logic aclk,
    input wire logic aresetn,
    output logic tick,
    output logic [1:0] row,
    output logic phase
);
    import lcd_pkg::*;

    scan_state_t s;
    scan_state_t n;

    // Each row gets two slots of opposite polarity, so the cell sees no DC
    always_comb begin
        n = s;
        n.tick = 1'b0;
        if (s.cnt == `SLOT_CNT_W'(SLOT_CYCLES - 1)) begin
            n.cnt = '0;
            n.tick = 1'b1;
            n.phase = ~s.phase;
            if (s.phase) begin
                n.row = s.row + 2'd1;
            end
        end else begin
            n.cnt = s.cnt + `SLOT_CNT_W'(1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign tick = s.tick;
    assign row = s.row;
    assign phase = s.phase;

    row_order_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $changed(s.row) |-> (s.row == $past(s.row) + 2'd1 && s.tick && !s.phase))
        else $error("backplane rows not scanned in order");

endmodule : scan_gen

/* host_model.sv */
// Host model: AXI4-Lite master that sends display bytes and settings
`timescale 1ns/10ps
`include "lcd_defs.svh"

module host_model (
    input wire logic aclk,
    output logic awvalid,
    input wire logic awready,
    output logic [7:0] awaddr,
    output logic wvalid,
    input wire logic wready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    input wire logic bvalid,
    output logic bready,
    input wire logic [1:0] bresp,
    output logic arvalid,
    input wire logic arready,
    output logic [7:0] araddr,
    input wire logic rvalid,
    output logic rready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp
);
    initial begin
        awvalid = 1'h0;
        wvalid = 1'h0;
        bready = 1'h0;
        arvalid = 1'h0;
        rready = 1'h0;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0000_0000;
        wstrb = 4'h0;
    end

    // Each channel is released only at the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r,
        input logic [3:0] s = 4'hf);
        logic done;
        done = 1'h0;
        @(posedge aclk);
        awvalid <= 1'h1;
        awaddr <= a;
        wvalid <= 1'h1;
        wdata <= d;
        wstrb <= s;
        bready <= 1'h1;
        while (!done) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
            if (bvalid) begin
                done = 1'h1;
                r = bresp;
                bready <= 1'h0;
            end
        end
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic done;
        done = 1'h0;
        @(posedge aclk);
        arvalid <= 1'h1;
        araddr <= a;
        rready <= 1'h1;
        while (!done) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'h0;
            if (rvalid) begin
                done = 1'h1;
                d = rdata;
                r = rresp;
                rready <= 1'h0;
            end
        end
    endtask : rd

    // Register select travels with every byte, so data never follows a stale selection
    task automatic put_byte(input logic [1:0] rs, input logic [7:0] b);
        logic [1:0] r;
        wr(`ADDR_BYTE, {22'h00_0000, rs, b}, r);
    endtask : put_byte

    // Pointer load command: tag 10 in the top two bits, column in the low six
    task automatic load_ptr(input logic [5:0] p);
        put_byte(2'h0, {2'h2, p});
    endtask : load_ptr
endmodule : host_model

/* lcd_display_ram_mux_scan_tb.sv */
// Self-checking bench for the LCD display memory and scan block
`timescale 1ns/10ps
`include "lcd_defs.svh"

module lcd_display_ram_mux_scan_tb;
    import lcd_pkg::*;
    localparam int SLOT = 8;
    localparam int AV [3] = '{2, 1, 3};
    logic aclk;
    logic aresetn;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    level_t [3:0] backplane_outputs;
    level_t [43:0] segment_outputs;
    logic [43:0] mem [4];
    logic [6:0] ptr;
    logic pv;
    int error_cnt;
    int n_tests;

    initial aclk = 1'h0;
    always #4 aclk = ~aclk;

    lcd_display_ram_mux_scan #(.SLOT_CYCLES(SLOT)) uut (.aclk, .aresetn, .awvalid, .awready,
        .awaddr, .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
        .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp,
        .backplane_outputs, .segment_outputs);

    host_model host (.aclk, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
        .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp);

    // ----------------------------------------
    // Compare and model tasks
    // ----------------------------------------
    task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk32

    task automatic chk_out(input string nm, input logic [143:0] e, input logic [143:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk_out

    task automatic close_out();
        $display("errors %0d checks %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out

    // Model keeps its own pointer; last byte at column 43 loses its low nibble
    task automatic data(input logic [7:0] b);
        host.put_byte(2'h1, b);
        if (pv && ptr < 44) begin
            for (int k = 0; k < 4; k++) begin
                mem[k][ptr] = b[7 - k];
                if (ptr < 43) mem[k][ptr + 1] = b[3 - k];
            end
            ptr = (ptr > 42) ? 7'd44 : ptr + 7'd2;
        end
    endtask : data

    task automatic load(input logic [5:0] p);
        host.load_ptr(p);
        pv = p < 44;
        if (pv) ptr = {1'h0, p};
    endtask : load

    task automatic st();
        host.rd(`ADDR_STATUS, d, r);
        chk32("status", {24'h00_0000, ptr == 7'd44, 1'h0, ptr[5:0]}, {24'h00_0000, d[7:0]});
    endtask : st

    // One full frame: find the selected backplane and phase, then predict every level
    task automatic frame(input int a);
        logic [143:0] e;
        logic [3:0] seen;
        int row;
        logic ph;
        seen = 4'h0;
        repeat (2 * SLOT + 4) @(posedge aclk);
        repeat (8 * SLOT) begin
            @(negedge aclk);
            ph = 1'h1;
            row = 0;
            for (int i = 0; i < 4; i++) begin
                if (backplane_outputs[i] === 3'(a + 1)) begin
                    ph = 1'h0;
                    row = i;
                end
            end
            for (int i = 0; i < 4; i++) begin
                if (ph && backplane_outputs[i] === 3'h0) row = i;
            end
            seen[row] = 1'h1;
            for (int i = 0; i < 4; i++) begin
                e[i * 3 +: 3] = 3'(i == row ? (ph ? 0 : a + 1) : (ph ? a : 1));
            end
            for (int c = 0; c < 44; c++) begin
                e[12 + c * 3 +: 3] = 3'(mem[row][c] ? (ph ? a + 1 : 0) : (ph ? a - 1 : 2));
            end
            chk_out("drive", e, {segment_outputs, backplane_outputs});
        end
        chk32("rows", 32'h0000_000f, {28'h000_0000, seen});
    endtask : frame

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        error_cnt = 0;
        n_tests = 0;
        aresetn = 1'h0;
        pv = 1'h1;
        ptr = 7'd0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        for (int pass = 0; pass < 2; pass++) begin
            repeat (2) @(posedge aclk);
            chk_out("idle", 144'h0, {segment_outputs, backplane_outputs});
            host.rd(`ADDR_CONFIG, d, r);
            chk32("config", 32'h0000_0000, d);
            st();
            if (pass == 0) begin
                for (int i = 0; i < 22; i++) data(8'(i * 37 + 5));
                st();
                data(8'hff);
            end
            host.wr(`ADDR_CONFIG, 32'h0000_0004, r);
            frame(2);
            if (pass == 0) begin
                load(6'd43);
                data(8'ha5);
                st();
                load(6'd44);
                host.rd(`ADDR_STATUS, d, r);
                chk32("invalid", 32'h0000_0001, {31'h0000_0000, d[6]});
                data(8'h3c);
                load(6'd5);
                data(8'h5a);
                data(8'hc3);
                host.put_byte(2'h2, 8'hff);
                host.put_byte(2'h0, 8'h01);
                host.wr(`ADDR_BYTE, 32'h0000_01ff, r, 4'h1);
                chk32("strobe", {30'h0000_0000, `RESP_OKAY}, {30'h0000_0000, r});
                st();
                for (int k = 0; k < 3; k++) begin
                    host.wr(`ADDR_CONFIG, 32'(4 + k), r);
                    host.rd(`ADDR_CONFIG, d, r);
                    chk32("bias", 32'(4 + k), d);
                    frame(AV[k]);
                end
                host.wr(`ADDR_CONFIG, 32'h0000_0007, r);
                chk32("wresp", {30'h0000_0000, `RESP_OKAY}, {30'h0000_0000, r});
                host.rd(`ADDR_CONFIG, d, r);
                chk32("reserved", 32'h0000_0006, d);
                chk32("cresp", {30'h0000_0000, `RESP_OKAY}, {30'h0000_0000, r});
                host.wr(8'h0c, 32'h0000_0000, r);
                chk32("bresp", {30'h0000_0000, `RESP_SLVERR}, {30'h0000_0000, r});
                host.rd(8'h0c, d, r);
                chk32("rresp", {30'h0000_0000, `RESP_SLVERR}, {30'h0000_0000, r});
                chk32("rdata", 32'h0000_0000, d);
                @(posedge aclk);
                aresetn <= 1'h0;
                repeat (3) @(posedge aclk);
                aresetn <= 1'h1;
                ptr = 7'd0;
                pv = 1'h1;
            end
        end
        close_out();
    end

    // Whole run needs under a thousand cycles; this limit of 40000 cycles is far beyond it
    initial begin
        #(8 * 40000);
        error_cnt++;
        close_out();
    end
endmodule : lcd_display_ram_mux_scan_tb
